// *** src/lcd_cmd_map.svh ***
`ifndef LCD_CMD_MAP_SVH
`define LCD_CMD_MAP_SVH

// Command opcodes
`define OP_CONTRAST 8'h82
`define OP_RIGHT 8'h83
`define OP_LEFT 8'h84
`define OP_SHIFT_R 8'h85
`define OP_SHIFT_L 8'h86
`define OP_SHIFT_UP 8'h87
`define OP_SHIFT_DN 8'h88
`define OP_SET_ADDR 8'h89
`define OP_SET_POS 8'h8a
`define OP_HOME 8'h8b
`define OP_CLEAR 8'h8c

// Display RAM geometry
`define SPACE_CHAR 8'h20
`define RAM_CELLS 80
`define LINE_LEN 7'h28
`define LINE1_FIRST 7'h00
`define LINE1_LAST 7'h27
`define LINE2_FIRST 7'h40
`define LINE2_LAST 7'h67
`define LINE2_IDX_OFS 7'h18
`define WRAP_L1_BACK 7'h53
`define WRAP_L2_BACK 7'h28
`define SMALL_COLS 7'h10
`define LOWER_ROW_BASE 7'h14
`define ROW_THREE 8'h03

// Contrast limits and reset values
`define CONTRAST_MAX 8'hfe
`define CONTRAST_RESET 8'h80
`define CURSOR_RESET 7'h00
`define SHIFT_RESET 6'h00

`endif

// *** src/lcd_cmd_pkg.sv ***
package lcd_cmd_pkg;
    `include "lcd_cmd_map.svh"

    // Command parser position, one-hot
    typedef enum logic [2:0] {
        ST_OP = 3'b001,
        ST_P1 = 3'b010,
        ST_P2 = 3'b100
    } parse_state_e;

    typedef logic [6:0] dram_addr_t;
    typedef logic [`RAM_CELLS-1:0][7:0] dram_t;

    // Whole state of the interpreter
    typedef struct packed {
        parse_state_e state;
        logic [7:0] opcode;
        logic [7:0] param;
        dram_addr_t cursor;
        logic [5:0] shift;
        logic [7:0] contrast;
        logic [7:0] rd_data;
        logic done;
        dram_t ram;
    } core_s;
endpackage : lcd_cmd_pkg

// *** src/cursor_calc.sv ***
`timescale 1ns/1ns
`include "lcd_cmd_map.svh"
module cursor_calc (
    input wire lcd_cmd_pkg::dram_addr_t cur, // Present cursor address
    input wire logic [7:0] row,              // Row, counted from 1
    input wire logic [7:0] col,              // Column, counted from 1
    input wire logic [5:0] shift,            // Accumulated display shift
    output lcd_cmd_pkg::dram_addr_t fwd,     // Cursor one place right
    output lcd_cmd_pkg::dram_addr_t back,    // Cursor one place left
    output lcd_cmd_pkg::dram_addr_t rc_addr  // Address of visible cell
);
    import lcd_cmd_pkg::*;

    logic [6:0] col_base;
    logic [6:0] pos_sum;
    logic [6:0] pos;

    // Forward step hops from the end of line 1 onto line 2
    always_comb begin
        if (cur == `LINE1_LAST) begin
            fwd = `LINE2_FIRST;
        end else if (cur == `LINE2_LAST) begin
            fwd = `LINE1_FIRST;
        end else begin
            fwd = 7'(cur + 7'h01);
        end
    end

    // Backward step wraps at each line start
    always_comb begin
        if (cur == `LINE1_FIRST) begin
            back = `WRAP_L1_BACK;
        end else if (cur == `LINE2_FIRST) begin
            back = `WRAP_L2_BACK;
        end else begin
            back = 7'(cur - 7'h01);
        end
    end

    // Rows 3 and 4 sit in the back half of lines 1 and 2
    always_comb begin
        col_base = (row >= `ROW_THREE) ? `LOWER_ROW_BASE : 7'h00;
        // Column 0 is outside the host's range; it is not guarded
        pos_sum = 7'(col_base + col[6:0] - 7'h01 + {1'b0, shift});
        pos = (pos_sum >= `LINE_LEN) ? 7'(pos_sum - `LINE_LEN) : pos_sum;
        // Even rows live on line 2
        rc_addr = row[0] ? pos : 7'(`LINE2_FIRST + pos);
    end
endmodule : cursor_calc

// *** src/lcd_cursor_shift_commands.sv ***
`timescale 1ns/1ns
`include "lcd_cmd_map.svh"
module lcd_cursor_shift_commands #(
    parameter bit FOUR_ROW = 1'b0 // 0: two rows of 16, 1: four rows of 20
) (
    input wire logic clk,                      // System clock
    input wire logic rst_n,                    // Asynchronous reset
    input wire logic byte_valid,               // Host byte present
    input wire logic [7:0] byte_data,          // Opcode, parameter or character
    output logic byte_ready,                   // Byte taken this cycle
    input wire lcd_cmd_pkg::dram_addr_t rd_addr, // Refresh read address
    output logic [7:0] rd_data,                // Refresh data, one cycle later
    output lcd_cmd_pkg::dram_addr_t cursor_addr, // Cursor address
    output logic [5:0] shift_offset,           // Accumulated display shift
    output logic [7:0] contrast,               // Contrast level held
    output logic cmd_done                      // Command completed pulse
);
    import lcd_cmd_pkg::*;

    localparam logic [6:0] VIS_W = FOUR_ROW ? `LINE_LEN : `SMALL_COLS;

    // Whole interpreter state and its next value
    core_s q_reg;
    core_s q_next;
    logic take_op;
    logic take_p1;
    logic take_p2;
    dram_addr_t calc_fwd;
    dram_addr_t calc_back;
    dram_addr_t calc_rc;
    logic [5:0] sh_dec;
    logic [5:0] sh_inc;
    logic [5:0] last_old;
    logic [5:0] last_new;

    // Cells outside both lines are not backed by storage
    function automatic logic ram_hit(input dram_addr_t a);
        ram_hit = (a <= `LINE1_LAST) || (a >= `LINE2_FIRST && a <= `LINE2_LAST);
    endfunction : ram_hit

    // Line 2 storage sits right after line 1's forty cells
    function automatic logic [6:0] ram_index(input dram_addr_t a);
        ram_index = (a <= `LINE1_LAST) ? a : 7'(a - `LINE2_IDX_OFS);
    endfunction : ram_index

    // Window arithmetic never leaves one forty-cell line
    function automatic logic [5:0] wrap40(input logic [6:0] s);
        wrap40 = (s >= `LINE_LEN) ? 6'(s - `LINE_LEN) : s[5:0];
    endfunction : wrap40

    // Cursor arithmetic kept apart so every command shares one copy
    cursor_calc u_calc (
        .cur(q_reg.cursor),
        .row(q_reg.param),
        .col(byte_data),
        .shift(q_reg.shift),
        .fwd(calc_fwd),
        .back(calc_back),
        .rc_addr(calc_rc)
    );

    // Nothing stalls the parser: every byte is taken in the cycle it is offered
    assign byte_ready = 1'b1;
    assign take_op = byte_valid && (q_reg.state == ST_OP);
    assign take_p1 = byte_valid && (q_reg.state == ST_P1);
    assign take_p2 = byte_valid && (q_reg.state == ST_P2);

    // Window edges before and after a one-place shift
    assign sh_dec = wrap40(7'({1'b0, q_reg.shift} + `LINE1_LAST));
    assign sh_inc = wrap40(7'({1'b0, q_reg.shift} + 7'h01));
    assign last_old = wrap40(7'({1'b0, q_reg.shift} + VIS_W - 7'h01));
    assign last_new = wrap40(7'({1'b0, sh_inc} + VIS_W - 7'h01));

    // Next state of the whole interpreter
    always_comb begin
        q_next = q_reg;
        q_next.done = 1'b0;
        q_next.rd_data = ram_hit(rd_addr) ? q_reg.ram[ram_index(rd_addr)] : `SPACE_CHAR;
        unique case (q_reg.state)
            ST_OP: begin
                if (byte_valid) begin
                    q_next.opcode = byte_data;
                    if (!byte_data[7]) begin
                        // Plain character lands at the cursor, then steps on
                        if (ram_hit(q_reg.cursor)) begin
                            q_next.ram[ram_index(q_reg.cursor)] = byte_data;
                        end
                        q_next.cursor = calc_fwd;
                        q_next.done = 1'b1;
                    end else begin
                        case (byte_data)
                            `OP_CONTRAST, `OP_SET_ADDR, `OP_SET_POS: begin
                                q_next.state = ST_P1;
                            end
                            `OP_RIGHT: begin
                                q_next.cursor = calc_fwd;
                                q_next.done = 1'b1;
                            end
                            `OP_LEFT: begin
                                q_next.cursor = calc_back;
                                q_next.done = 1'b1;
                            end
                            `OP_SHIFT_R: begin
                                // Window slides back; edge cells turn blank
                                q_next.shift = sh_dec;
                                q_next.ram[sh_dec] = `SPACE_CHAR;
                                q_next.ram[7'({1'b0, sh_dec} + `LINE_LEN)] = `SPACE_CHAR;
                                q_next.ram[last_old] = `SPACE_CHAR;
                                q_next.ram[7'({1'b0, last_old} + `LINE_LEN)] = `SPACE_CHAR;
                                q_next.done = 1'b1;
                            end
                            `OP_SHIFT_L: begin
                                // Lost cells are blanked so a reverse shift cannot restore
                                q_next.shift = sh_inc;
                                q_next.ram[q_reg.shift] = `SPACE_CHAR;
                                q_next.ram[7'({1'b0, q_reg.shift} + `LINE_LEN)] = `SPACE_CHAR;
                                q_next.ram[last_new] = `SPACE_CHAR;
                                q_next.ram[7'({1'b0, last_new} + `LINE_LEN)] = `SPACE_CHAR;
                                q_next.done = 1'b1;
                            end
                            `OP_SHIFT_UP: begin
                                for (int i = 0; i < `RAM_CELLS / 2; i++) begin
                                    q_next.ram[i] = q_reg.ram[i + `RAM_CELLS / 2];
                                    q_next.ram[i + `RAM_CELLS / 2] = `SPACE_CHAR;
                                end
                                q_next.done = 1'b1;
                            end
                            `OP_SHIFT_DN: begin
                                for (int i = 0; i < `RAM_CELLS / 2; i++) begin
                                    q_next.ram[i + `RAM_CELLS / 2] = q_reg.ram[i];
                                    q_next.ram[i] = `SPACE_CHAR;
                                end
                                q_next.done = 1'b1;
                            end
                            `OP_HOME: begin
                                q_next.cursor = `CURSOR_RESET;
                                q_next.done = 1'b1;
                            end
                            `OP_CLEAR: begin
                                q_next.cursor = `CURSOR_RESET;
                                q_next.shift = `SHIFT_RESET;
                                q_next.ram = {`RAM_CELLS{`SPACE_CHAR}};
                                q_next.done = 1'b1;
                            end
                            default: begin
                                // Opcodes of other blocks pass by untouched
                                q_next.done = 1'b0;
                            end
                        endcase
                    end
                end
            end
            ST_P1: begin
                if (byte_valid) begin
                    if (q_reg.opcode == `OP_SET_POS) begin
                        q_next.param = byte_data;
                        q_next.state = ST_P2;
                    end else begin
                        if (q_reg.opcode == `OP_CONTRAST) begin
                            // Out-of-range values are held at the top level
                            q_next.contrast = (byte_data > `CONTRAST_MAX) ?
                                `CONTRAST_MAX : byte_data;
                        end else begin
                            q_next.cursor = byte_data[6:0];
                        end
                        q_next.state = ST_OP;
                        q_next.done = 1'b1;
                    end
                end
            end
            ST_P2: begin
                if (byte_valid) begin
                    q_next.cursor = calc_rc;
                    q_next.state = ST_OP;
                    q_next.done = 1'b1;
                end
            end
            default: begin
                q_next.state = ST_OP;
            end
        endcase
    end

    // State register; display RAM comes up blank
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= '{state: ST_OP, opcode: 8'h00, param: 8'h00,
                       cursor: `CURSOR_RESET, shift: `SHIFT_RESET,
                       contrast: `CONTRAST_RESET, rd_data: `SPACE_CHAR,
                       done: 1'b0, ram: {`RAM_CELLS{`SPACE_CHAR}}};
        end else begin
            q_reg <= q_next;
        end
    end

    assign rd_data = q_reg.rd_data;
    assign cursor_addr = q_reg.cursor;
    assign shift_offset = q_reg.shift;
    assign contrast = q_reg.contrast;
    assign cmd_done = q_reg.done;

    // Checks share one clock; reset masks them so release itself is not judged
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_op(logic [7:0] op);
        take_op && byte_data == op;
    endsequence

    sequence s_param_cmd(logic [7:0] op);
        s_op(op) ##1 take_p1;
    endsequence

    // Row byte, then column byte, of a placement command
    sequence s_pos_cmd(logic [7:0] row_b, logic [7:0] col_b);
        s_param_cmd(`OP_SET_POS) ##0 byte_data == row_b ##1 take_p2 && byte_data == col_b;
    endsequence

    // Contrast load, and nothing acted on before its parameter
    a_contrast_load: assert property (s_param_cmd(`OP_CONTRAST)
        ##0 byte_data <= `CONTRAST_MAX |=> contrast == $past(byte_data))
        else $error("contrast not loaded");
    a_contrast_wait: assert property (s_op(`OP_CONTRAST)
        |=> $stable(contrast) && !cmd_done)
        else $error("contrast taken early");

    // Cursor steps and line wraps
    a_right_step: assert property (s_op(`OP_RIGHT) ##0 cursor_addr < `LINE1_LAST
        |=> cursor_addr == 7'($past(cursor_addr) + 7'h01) && $stable(q_reg.ram))
        else $error("right move wrong");
    a_right_wrap: assert property (s_op(`OP_RIGHT) ##0 cursor_addr == `LINE1_LAST
        |=> cursor_addr == `LINE2_FIRST)
        else $error("right wrap wrong");
    a_left_step: assert property (s_op(`OP_LEFT) ##0 cursor_addr > `LINE2_FIRST
        |=> cursor_addr == 7'($past(cursor_addr) - 7'h01) && $stable(q_reg.ram))
        else $error("left move wrong");
    a_left_line1: assert property (s_op(`OP_LEFT) ##0 cursor_addr > `LINE1_FIRST
        && cursor_addr <= `LINE1_LAST
        |=> cursor_addr == 7'($past(cursor_addr) - 7'h01) && $stable(q_reg.ram))
        else $error("line 1 left move wrong");
    a_left_wrap1: assert property (s_op(`OP_LEFT) ##0 cursor_addr == `LINE1_FIRST
        |=> cursor_addr == `WRAP_L1_BACK)
        else $error("line 1 left wrap wrong");
    a_left_wrap2: assert property (s_op(`OP_LEFT) ##0 cursor_addr == `LINE2_FIRST
        |=> cursor_addr == `WRAP_L2_BACK)
        else $error("line 2 left wrap wrong");

    // Display shifts keep the cursor and blank the cells entering the window on both lines
    a_shift_right: assert property (s_op(`OP_SHIFT_R) |=> $stable(cursor_addr)
        && q_reg.ram[shift_offset] == `SPACE_CHAR
        && shift_offset == wrap40(7'({1'b0, $past(shift_offset)} + `LINE1_LAST)))
        else $error("shift right wrong");
    a_shift_right_row2: assert property (s_op(`OP_SHIFT_R)
        |=> q_reg.ram[7'({1'b0, shift_offset} + `LINE_LEN)] == `SPACE_CHAR)
        else $error("shift right row 2 wrong");
    a_shift_left: assert property (s_op(`OP_SHIFT_L) |=> $stable(cursor_addr)
        && q_reg.ram[last_old] == `SPACE_CHAR)
        else $error("shift left wrong");
    a_shift_left_row2: assert property (s_op(`OP_SHIFT_L)
        |=> q_reg.ram[7'({1'b0, last_old} + `LINE_LEN)] == `SPACE_CHAR
        && shift_offset == wrap40(7'({1'b0, $past(shift_offset)} + 7'h01)))
        else $error("shift left row 2 wrong");

    // Row copies
    a_shift_up: assert property (s_op(`OP_SHIFT_UP)
        |=> q_reg.ram[0] == $past(q_reg.ram[40])
        && q_reg.ram[79] == `SPACE_CHAR && $stable(cursor_addr))
        else $error("shift up wrong");
    a_shift_down: assert property (s_op(`OP_SHIFT_DN)
        |=> q_reg.ram[79] == $past(q_reg.ram[39])
        && q_reg.ram[0] == `SPACE_CHAR && $stable(cursor_addr))
        else $error("shift down wrong");

    // Direct addressing and row and column placement
    a_addr_load: assert property (s_param_cmd(`OP_SET_ADDR)
        |=> cursor_addr == $past(byte_data[6:0]) && cmd_done)
        else $error("address load wrong");
    a_addr_wait: assert property (s_op(`OP_SET_ADDR) |=> $stable(cursor_addr) && !cmd_done)
        else $error("executed before parameter");
    a_pos_wait: assert property (s_param_cmd(`OP_SET_POS)
        |=> $stable(cursor_addr) && !cmd_done)
        else $error("placement executed early");
    a_pos_origin: assert property (s_pos_cmd(8'h01, 8'h01)
        |=> cursor_addr == 7'({1'b0, shift_offset}))
        else $error("row and column wrong");
    a_pos_row3: assert property (s_pos_cmd(`ROW_THREE, 8'h01)
        |=> cursor_addr == {1'b0, wrap40(7'({1'b0, shift_offset} + `LOWER_ROW_BASE))})
        else $error("row 3 placement wrong");

    // Home and clear
    a_home_keep: assert property (s_op(`OP_HOME) |=> cursor_addr == `CURSOR_RESET
        && $stable(q_reg.ram))
        else $error("home wrong");
    a_home_shift: assert property (s_op(`OP_HOME) |=> $stable(shift_offset) && cmd_done)
        else $error("home moved the window");
    a_clear_all: assert property (s_op(`OP_CLEAR) |=> cursor_addr == `CURSOR_RESET
        && q_reg.ram == {`RAM_CELLS{`SPACE_CHAR}})
        else $error("clear wrong");
    a_clear_shift: assert property (s_op(`OP_CLEAR)
        |=> shift_offset == `SHIFT_RESET && cmd_done)
        else $error("clear left the window shifted");

    // Characters land where the cursor stood; foreign opcodes change nothing
    a_char_land: assert property (take_op && !byte_data[7] && ram_hit(cursor_addr)
        |=> q_reg.ram[$past(ram_index(cursor_addr))] == $past(byte_data))
        else $error("character not stored");
    a_unknown_op: assert property (take_op && byte_data[7]
        && (byte_data < `OP_CONTRAST || byte_data > `OP_CLEAR)
        |=> !cmd_done && $stable(cursor_addr) && $stable(contrast))
        else $error("foreign opcode acted on");
endmodule : lcd_cursor_shift_commands

// *** verif/host_model.sv ***
`timescale 1ns/1ns
module host_model (
    input wire logic clk,          // System clock
    input wire logic cmd_done,     // Completion pulse from device
    output logic byte_valid,       // Byte offered
    output logic [7:0] byte_data   // Opcode, parameter or character
);
    // Bus idle from time zero
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
    end

    // One byte, held until the edge that takes it; done sampled once settled
    task automatic send_byte(input logic [7:0] b, output logic done);
        byte_valid = 1'b1;
        byte_data = b;
        @(posedge clk);
        #1;
        done = cmd_done;
    endtask : send_byte

    // Released data shows the inverse, so a stale byte never looks fresh
    task automatic release_bus();
        byte_valid = 1'b0;
        byte_data = ~byte_data;
        @(posedge clk);
        #1;
    endtask : release_bus

    // Parameters follow the opcode back to back, values kept in host range
    task automatic send_cmd(input logic [7:0] op, input int n, input logic [7:0] p0,
                            input logic [7:0] p1, output logic done);
        logic d;
        logic early;
        send_byte(op, d);
        early = 1'b0;
        if (n > 0) begin
            early = d;
            send_byte(p0, d);
        end
        if (n > 1) begin
            early = early | d;
            send_byte(p1, d);
        end
        // A done before the last byte, or one lasting two cycles, spoils it
        done = (early === 1'b0) ? d : 1'b0;
        release_bus();
        done = (cmd_done === 1'b0) ? done : 1'b0;
    endtask : send_cmd
endmodule : host_model

// *** verif/tb_lcd_cursor_shift_commands.sv ***
`timescale 1ns/1ns
`include "lcd_cmd_map.svh"
module tb_lcd_cursor_shift_commands;
    import lcd_cmd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic byte_valid;
    logic [7:0] byte_data;
    dram_addr_t rd_addr = 7'h00;
    logic [7:0] rd_data;
    dram_addr_t cursor_addr;
    dram_addr_t cursor_wide;
    logic [5:0] shift_offset;
    logic [7:0] contrast;
    logic cmd_done;
    logic byte_ready;
    int error_cnt = 0;
    int comparisons = 0;
    logic [7:0] vis [0:1][0:15]; // Expected visible screen
    int exp_shift = 0;

    always #5 clk = ~clk;

    host_model host_model_inst (.clk(clk), .cmd_done(cmd_done), .byte_valid(byte_valid),
        .byte_data(byte_data));
    lcd_cursor_shift_commands #(.FOUR_ROW(1'b0)) lcd_cursor_shift_commands_inst (
        .clk(clk), .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready(byte_ready), .rd_addr(rd_addr), .rd_data(rd_data), .cursor_addr(cursor_addr),
        .shift_offset(shift_offset), .contrast(contrast), .cmd_done(cmd_done));
    // Four-row variant fed the same bytes; only its cursor is judged
    lcd_cursor_shift_commands #(.FOUR_ROW(1'b1)) lcd_cursor_shift_commands_wide_inst (
        .clk(clk), .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready(), .rd_addr(rd_addr), .rd_data(), .cursor_addr(cursor_wide),
        .shift_offset(), .contrast(), .cmd_done());

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check

    task automatic do_cmd(input logic [7:0] op, input int n, input logic [7:0] p0,
                          input logic [7:0] p1, input logic exp_done);
        logic d;
        host_model_inst.send_cmd(op, n, p0, p1, d);
        check({7'h00, d}, {7'h00, exp_done});
    endtask : do_cmd

    // Visible cell read through the window offset that the bench tracks
    task automatic check_screen();
        logic [7:0] v;
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 16; c++) begin
                rd_addr = 7'((r * 64) + ((exp_shift + c) % 40));
                @(posedge clk);
                #1;
                v = rd_data;
                check(v, vis[r][c]);
            end
        end
        check({2'b00, shift_offset}, 8'(exp_shift));
    endtask : check_screen

    task automatic check_cursor(input logic [7:0] exp);
        check({1'b0, cursor_addr}, exp);
    endtask : check_cursor

    task automatic test_reset();
        check_cursor(8'h00);
        check({2'b00, shift_offset}, 8'h00);
        check(contrast, 8'h80);
        check(rd_data, 8'h20);
        check({7'h00, byte_ready}, 8'h01);
    endtask : test_reset

    // Ends of the range, a parameter above 0x7f, then an unknown opcode
    task automatic test_contrast();
        do_cmd(`OP_CONTRAST, 1, 8'h00, 8'h00, 1'b1);
        check(contrast, 8'h00);
        do_cmd(`OP_CONTRAST, 1, 8'hfe, 8'h00, 1'b1);
        check(contrast, 8'hfe);
        do_cmd(`OP_CONTRAST, 1, 8'h8c, 8'h00, 1'b1);
        check(contrast, 8'h8c);
        do_cmd(8'h81, 0, 8'h00, 8'h00, 1'b0);
        check(contrast, 8'h8c);
    endtask : test_contrast

    task automatic clear_screen();
        do_cmd(`OP_CLEAR, 0, 8'h00, 8'h00, 1'b1);
        exp_shift = 0;
        for (int c = 0; c < 16; c++) begin
            vis[0][c] = 8'h20;
            vis[1][c] = 8'h20;
        end
        check({1'b0, cursor_addr}, 8'h00);
        check_screen();
    endtask : clear_screen

    task automatic fill_screen();
        for (int r = 0; r < 2; r++) begin
            do_cmd(`OP_SET_ADDR, 1, (r == 1) ? 8'h40 : 8'h00, 8'h00, 1'b1);
            for (int c = 0; c < 16; c++) begin
                vis[r][c] = 8'(((r == 1) ? 8'h61 : 8'h41) + c);
                do_cmd(vis[r][c], 0, 8'h00, 8'h00, 1'b1);
            end
        end
        check_screen();
    endtask : fill_screen

    // Wrap points on both lines, plain steps, RAM left alone
    task automatic test_moves();
        logic [7:0] st [0:4] = '{8'h27, 8'h05, 8'h00, 8'h40, 8'h06};
        logic [7:0] op [0:4] = '{`OP_RIGHT, `OP_RIGHT, `OP_LEFT, `OP_LEFT, `OP_LEFT};
        logic [7:0] ex [0:4] = '{8'h40, 8'h06, 8'h53, 8'h28, 8'h05};
        for (int i = 0; i < 5; i++) begin
            do_cmd(`OP_SET_ADDR, 1, st[i], 8'h00, 1'b1);
            check({1'b0, cursor_addr}, st[i]);
            do_cmd(op[i], 0, 8'h00, 8'h00, 1'b1);
            check({1'b0, cursor_addr}, ex[i]);
        end
        check_screen();
        do_cmd(`OP_RIGHT, 0, 8'h00, 8'h00, 1'b1);
        do_cmd(8'h5a, 0, 8'h00, 8'h00, 1'b1);
        vis[0][6] = 8'h5a;
        check_cursor(8'h07);
        check_screen();
    endtask : test_moves

    task automatic shift_once(input logic right);
        do_cmd(right ? `OP_SHIFT_R : `OP_SHIFT_L, 0, 8'h00, 8'h00, 1'b1);
        exp_shift = right ? (exp_shift + 39) % 40 : (exp_shift + 1) % 40;
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 15; c++) begin
                if (right) vis[r][15 - c] = vis[r][14 - c];
                else vis[r][c] = vis[r][c + 1];
            end
            vis[r][right ? 0 : 15] = 8'h20;
        end
        check_cursor(8'h07);
        check_screen();
    endtask : shift_once

    task automatic set_rc(input logic [7:0] r, input logic [7:0] c, input logic [7:0] exp);
        do_cmd(`OP_SET_POS, 2, r, c, 1'b1);
        check({1'b0, cursor_addr}, exp);
    endtask : set_rc

    task automatic set_rc_wide(input logic [7:0] r, input logic [7:0] c,
                               input logic [7:0] exp);
        do_cmd(`OP_SET_POS, 2, r, c, 1'b1);
        check({1'b0, cursor_wide}, exp);
    endtask : set_rc_wide

    // Row copies leave the cursor where it stands, then home sends it to address 0
    task automatic test_rows();
        do_cmd(`OP_SET_ADDR, 1, 8'h05, 8'h00, 1'b1);
        do_cmd(`OP_SHIFT_UP, 0, 8'h00, 8'h00, 1'b1);
        vis[0] = vis[1];
        vis[1] = '{default: 8'h20};
        check({1'b0, cursor_addr}, 8'h05);
        check_screen();
        do_cmd(8'h7e, 0, 8'h00, 8'h00, 1'b1);
        vis[0][(45 - exp_shift) % 40] = 8'h7e; // Address 5 seen through the window
        do_cmd(`OP_SHIFT_DN, 0, 8'h00, 8'h00, 1'b1);
        vis[1] = vis[0];
        vis[0] = '{default: 8'h20};
        check({1'b0, cursor_addr}, 8'h06);
        check_screen();
        do_cmd(`OP_HOME, 0, 8'h00, 8'h00, 1'b1);
        check({1'b0, cursor_addr}, 8'h00);
        check_screen();
    endtask : test_rows

    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // Whole run needs about 500 cycles; this cuts a hang short
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        test_reset();
        test_contrast();
        clear_screen();
        fill_screen();
        test_moves();
        shift_once(1'b1);
        shift_once(1'b1);
        shift_once(1'b0);
        set_rc(8'h01, 8'h01, 8'(exp_shift));
        set_rc(8'h02, 8'h10, 8'(64 + (exp_shift + 15) % 40));
        test_rows();
        clear_screen();
        set_rc(8'h01, 8'h10, 8'h0f);
        set_rc(8'h02, 8'h10, 8'h4f);
        set_rc_wide(8'h02, 8'h14, 8'h53);
        set_rc_wide(8'h03, 8'h01, 8'h14);
        set_rc_wide(8'h04, 8'h14, 8'h67);
        final_report();
    end
endmodule : tb_lcd_cursor_shift_commands
